// >>> core/analog_select_math.sv
// Purpose: selector and arithmetic blocks with a shared running-value word file
// Assumes: control inputs come from logic on ref_clk_i; wishbone classic slave
// Notes: ack one cycle after the request; writes commit on the ack edge
//
// Function
// (RL1) The selector updates its output only on a rising edge of its enable.
// (RL2) Selects low/high pick preset one, two, three or four as {high,low} counts 0 to 3.
// (RL3) Each preset accepts only signed hundredths within -20000.00 to 20000.00.
// (RL4) Both blocks keep their running value in their own shared word and parameter output.
// (RL5) The arithmetic block evaluates when its enable rises from 0 to 1.
// (RL6) The arithmetic reset returns the block and its result to the reset state.
// (RL7) A divide by zero or a result magnitude above 99999999 is an error.
// (RL8) The expression always has four operands joined by three operators.
// (RL9) Each operator is add, subtract, multiply or divide.
// (RL10) Priorities high, medium, low are distinct and applied in that order.
// (RL11) An option holds the last result or forces zero while the enable is low.
// (RL12) Users pad unused terms with plus zero or times one.
// (RL13) A parameter may be taken from a shared word instead of its preset.
// (RL14) Edits to a parameter sourced from a shared word are refused.
// (RL15) Using a shared word that was never written raises an error.
// (RL16) An arithmetic error sets a sticky flag, cleared by reset, and keeps the result.
`timescale 1ns/1ps
module analog_select_math (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [6:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// selector block
	input wire logic sel_enable_i,
	input wire logic select_high_i,
	input wire logic select_low_i,
	output logic [31:0] sel_value_o,
	output logic [31:0] sel_param_o,
	// arithmetic block
	input wire logic math_enable_i,
	input wire logic math_reset_i,
	output logic [31:0] arith_result_o,
	output logic [31:0] math_param_o,
	output logic math_error_o,
	// interrupt
	output logic irq_o
);
	abm_pkg::ctrl_t ctrl;
	logic [abm_pkg::ST_W-1:0] status;
	logic [abm_pkg::ST_W-1:0] mask;
	logic [3:0][31:0] preset;
	logic [3:0][31:0] operand;
	abm_pkg::op_cfg_t [2:0] op_cfg;
	logic [3:0][31:0] running_value_word;
	logic [3:0] dw_written;
	logic err_flag;
	abm_pkg::math_state_t mstate;
	logic signed [63:0] val [4];
	logic [1:0] grp [4];
	logic [1:0] step;
	logic [31:0] arith_result;
	logic math_en_q;

	// bus decode
	logic req;
	logic wr;
	logic [6:0] offs;
	logic [31:0] wdata_mask;
	logic [31:0] rdata;

	assign req = cyc_i & stb_i;
	assign wr = req & we_i & ack_o;
	assign offs = {adr_i[6:2], 2'h0};
	assign wdata_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req & ~ack_o;
		end
	end

	// effective parameters, possibly from the shared words
	logic [3:0][31:0] preset_eff;
	logic [3:0][31:0] operand_eff;
	always_comb begin
		preset_eff = preset;
		operand_eff = operand;
		if (ctrl.preset_src_dw) begin
			preset_eff[0] = running_value_word[ctrl.preset_idx]; // RL13
		end
		if (ctrl.operand_src_dw) begin
			operand_eff[0] = running_value_word[ctrl.operand_idx]; // RL13
		end
	end

	// selector
	logic [31:0] sel_value;
	logic sel_update;
	preset_value_selector i_preset_value_selector (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.enable_i(sel_enable_i),
		.select_high_i(select_high_i),
		.select_low_i(select_low_i),
		.presets_i(preset_eff),
		.value_o(sel_value),
		.update_o(sel_update)
	);

	// arithmetic evaluation
	logic math_start;
	logic pri_ok;
	logic [1:0] cur;
	logic [1:0] nxt;
	logic signed [63:0] op_res;
	logic op_err;
	logic step_ok;
	logic step_err;
	logic math_done;

	assign math_start = math_enable_i & ~math_en_q & ~math_reset_i; // RL5
	assign pri_ok = (op_cfg[0].pri != op_cfg[1].pri) & (op_cfg[0].pri != op_cfg[2].pri)
		& (op_cfg[1].pri != op_cfg[2].pri) & (op_cfg[0].pri <= abm_pkg::PRI_LOW)
		& (op_cfg[1].pri <= abm_pkg::PRI_LOW) & (op_cfg[2].pri <= abm_pkg::PRI_LOW); // RL10

	always_comb begin
		cur = 2'h0;
		for (int i = 0; i < abm_pkg::NUM_OPS; i++) begin
			if (op_cfg[i].pri == step) begin // RL10
				cur = 2'(i);
			end
		end
		nxt = cur + 2'h1;
	end

	math_op_unit i_math_op_unit (
		.a_i(val[grp[cur]]),
		.b_i(val[grp[nxt]]),
		.op_i(op_cfg[cur].op),
		.res_o(op_res),
		.error_o(op_err)
	);

	assign step_ok = (mstate == abm_pkg::MS_EVAL) & ~op_err & ~math_reset_i;
	assign step_err = ((mstate == abm_pkg::MS_EVAL) & op_err & ~math_reset_i)
		| (math_start & ~pri_ok);
	assign math_done = step_ok & (step == abm_pkg::PRI_LOW);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i | math_reset_i) begin // RL6
			math_en_q <= 1'b0;
		end else begin
			math_en_q <= math_enable_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i | math_reset_i) begin // RL6
			mstate <= abm_pkg::MS_IDLE;
			step <= abm_pkg::PRI_HIGH;
		end else begin
			unique case (mstate)
				abm_pkg::MS_IDLE: begin
					if (math_start & pri_ok) begin
						mstate <= abm_pkg::MS_EVAL;
						step <= abm_pkg::PRI_HIGH;
					end
				end
				abm_pkg::MS_EVAL: begin
					if (op_err | math_done) begin
						mstate <= abm_pkg::MS_IDLE;
					end else begin
						step <= step + 2'h1;
					end
				end
			endcase
		end
	end

	// terms collapse into groups; a group's value sits at its leftmost term
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int j = 0; j < abm_pkg::NUM_TERMS; j++) begin
				val[j] <= '0;
				grp[j] <= 2'h0;
			end
		end else if (math_start & mstate == abm_pkg::MS_IDLE) begin
			for (int j = 0; j < abm_pkg::NUM_TERMS; j++) begin // RL8
				val[j] <= {{32{operand_eff[j][31]}}, operand_eff[j]};
				grp[j] <= 2'(j);
			end
		end else if (step_ok) begin
			val[grp[cur]] <= op_res;
			for (int j = 0; j < abm_pkg::NUM_TERMS; j++) begin
				if (grp[j] == grp[nxt]) begin
					grp[j] <= grp[cur];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i | math_reset_i) begin // RL6
			arith_result <= '0;
		end else if (~math_enable_i & ~ctrl.hold_last) begin // RL11
			arith_result <= '0;
		end else if (math_done) begin
			arith_result <= op_res[31:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i | math_reset_i) begin
			err_flag <= 1'b0;
		end else if (step_err) begin // RL16
			err_flag <= 1'b1;
		end
	end

	// shared running-value words: 0 selector, 1 arithmetic, 2 and 3 software
	logic dw_missing;
	assign dw_missing = (sel_update & ctrl.preset_src_dw & ~dw_written[ctrl.preset_idx])
		| (math_start & ctrl.operand_src_dw & ~dw_written[ctrl.operand_idx]); // RL15

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			running_value_word <= '0;
			dw_written <= '0;
		end else begin
			running_value_word[0] <= sel_value; // RL4
			running_value_word[1] <= arith_result; // RL4
			if (sel_update) begin
				dw_written[0] <= 1'b1;
			end
			if (math_done) begin
				dw_written[1] <= 1'b1;
			end
			for (int k = 2; k < abm_pkg::NUM_TERMS; k++) begin
				if (wr & offs == abm_pkg::REG_DW + 7'(4 * k)) begin
					running_value_word[k] <= merge(running_value_word[k], dat_i, wdata_mask);
					dw_written[k] <= 1'b1;
				end
			end
		end
	end

	// parameter registers
	logic edit_refused;
	logic [31:0] cand;
	logic in_range;
	assign cand = merge(preset[adr_i[3:2]], dat_i, wdata_mask);
	assign in_range = ($signed(cand) <= abm_pkg::PRESET_MAX)
		& ($signed(cand) >= abm_pkg::PRESET_MIN);

	always_comb begin
		edit_refused = 1'b0;
		if (wr & offs[6:4] == abm_pkg::REG_PRESET[6:4]) begin
			edit_refused = ~in_range // RL3
				| (ctrl.preset_src_dw & adr_i[3:2] == 2'h0); // RL14
		end
		if (wr & offs[6:4] == abm_pkg::REG_OPERAND[6:4]) begin
			edit_refused = ctrl.operand_src_dw & adr_i[3:2] == 2'h0; // RL14
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl <= '0;
			mask <= '0;
			preset <= '0;
			operand <= '0;
			op_cfg <= {abm_pkg::op_cfg_t'({abm_pkg::PRI_LOW, abm_pkg::OP_ADD}),
				abm_pkg::op_cfg_t'({abm_pkg::PRI_MID, abm_pkg::OP_ADD}),
				abm_pkg::op_cfg_t'({abm_pkg::PRI_HIGH, abm_pkg::OP_ADD})};
		end else if (wr & ~edit_refused) begin
			if (offs == abm_pkg::REG_CTRL) begin
				ctrl <= abm_pkg::ctrl_t'(merge(32'(ctrl), dat_i, wdata_mask));
			end
			if (offs == abm_pkg::REG_MASK) begin
				mask <= abm_pkg::ST_W'(merge(32'(mask), dat_i, wdata_mask));
			end
			if (offs[6:4] == abm_pkg::REG_PRESET[6:4]) begin
				preset[adr_i[3:2]] <= cand;
			end
			if (offs[6:4] == abm_pkg::REG_OPERAND[6:4]) begin
				operand[adr_i[3:2]] <= merge(operand[adr_i[3:2]], dat_i, wdata_mask);
			end
			if (offs == abm_pkg::REG_OPCFG) begin
				op_cfg <= 12'(merge(32'(op_cfg), dat_i, wdata_mask));
			end
		end
	end

	// interrupt status, set wins over a write-one clear
	logic [abm_pkg::ST_W-1:0] events;
	logic [abm_pkg::ST_W-1:0] clr;
	always_comb begin
		events = '0;
		events[abm_pkg::ST_SEL] = sel_update;
		events[abm_pkg::ST_DONE] = math_done;
		events[abm_pkg::ST_ERR] = step_err;
		events[abm_pkg::ST_MISSING] = dw_missing;
		events[abm_pkg::ST_REFUSED] = edit_refused;
		clr = '0;
		if (wr & offs == abm_pkg::REG_STATUS) begin
			clr = abm_pkg::ST_W'(dat_i & wdata_mask);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			status <= '0;
		end else begin
			status <= (status & ~clr) | events;
		end
	end

	assign irq_o = |(status & mask);

	// read back, registered on the edge that raises ack
	always_comb begin
		rdata = '0;
		if (offs == abm_pkg::REG_CTRL) rdata = 32'(ctrl);
		if (offs == abm_pkg::REG_STATUS) rdata = 32'(status);
		if (offs == abm_pkg::REG_MASK) rdata = 32'(mask);
		if (offs == abm_pkg::REG_STATE) rdata = 32'({dw_written, step, mstate, err_flag});
		if (offs[6:4] == abm_pkg::REG_PRESET[6:4]) rdata = preset[adr_i[3:2]];
		if (offs[6:4] == abm_pkg::REG_OPERAND[6:4]) rdata = operand[adr_i[3:2]];
		if (offs == abm_pkg::REG_OPCFG) rdata = 32'(op_cfg);
		if (offs == abm_pkg::REG_SEL_OUT) rdata = sel_value;
		if (offs == abm_pkg::REG_MATH_OUT) rdata = arith_result;
		if (offs[6:4] == abm_pkg::REG_DW[6:4]) rdata = running_value_word[adr_i[3:2]];
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (req & ~ack_o) begin
			dat_o <= rdata;
		end
	end

	assign sel_value_o = sel_value;
	assign sel_param_o = running_value_word[0];
	assign arith_result_o = arith_result;
	assign math_param_o = running_value_word[1];
	assign math_error_o = err_flag;

	// checks
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_sel_hold: assert property (~sel_update |=> $stable(sel_value)) // RL1
		else $error("selector changed without an enable edge");
	a_sel_pick: assert property (sel_update |=>
		sel_value == $past(preset_eff[{select_high_i, select_low_i}])) // RL2
		else $error("selector picked the wrong preset");
	a_preset_bound: assert property ($signed(preset[1]) <= abm_pkg::PRESET_MAX
		&& $signed(preset[1]) >= abm_pkg::PRESET_MIN) // RL3
		else $error("preset outside its range");
	a_dw_track: assert property (##1 running_value_word[1] == $past(arith_result)) // RL4
		else $error("shared word does not follow the result");
	a_math_run: assert property (math_start && pri_ok && mstate == abm_pkg::MS_IDLE
		|=> mstate == abm_pkg::MS_EVAL ##[1:3] mstate == abm_pkg::MS_IDLE) // RL5
		else $error("evaluation did not start or end in time");
	a_math_reset: assert property (math_reset_i |=> arith_result == '0 && !err_flag) // RL6
		else $error("arithmetic reset left state behind");
	a_err_keep: assert property (step_err && math_enable_i |=> err_flag
		&& $stable(arith_result)) // RL16
		else $error("error did not latch or result moved");
	a_zero_off: assert property (!math_enable_i && !ctrl.hold_last && !math_reset_i
		|=> arith_result == '0) // RL11
		else $error("disabled result not forced to zero");
	a_refuse_edit: assert property (wr && edit_refused |=> $stable(preset)
		&& $stable(operand)) // RL14
		else $error("refused edit changed a parameter");
	a_irq_level: assert property (status[abm_pkg::ST_ERR] && mask[abm_pkg::ST_ERR] |-> irq_o)
		else $error("unmasked status without interrupt");

	c_sel_update: cover property (sel_update ##1 sel_value != '0);
	c_math_done: cover property (math_start ##[1:4] math_done);
	c_math_err: cover property (mstate == abm_pkg::MS_EVAL && op_err);
	c_dw_missing: cover property (dw_missing);
endmodule

// >>> core/abm_pkg.sv
// Purpose: shared constants and types for the selector and arithmetic blocks
// Assumes: 32-bit classic wishbone slave, byte addresses, one word per register
// Notes: selector values are hundredths; arithmetic operands are plain integers
package abm_pkg;
	localparam int DATA_W = 32;
	localparam int WIDE_W = 64;
	localparam int NUM_TERMS = 4;
	localparam int NUM_OPS = 3;
	localparam int OPCFG_STRIDE = 4;

	// register byte offsets
	localparam logic [6:0] REG_CTRL = 7'h00;
	localparam logic [6:0] REG_STATUS = 7'h04;
	localparam logic [6:0] REG_MASK = 7'h08;
	localparam logic [6:0] REG_STATE = 7'h0c;
	localparam logic [6:0] REG_PRESET = 7'h10;
	localparam logic [6:0] REG_OPERAND = 7'h20;
	localparam logic [6:0] REG_OPCFG = 7'h30;
	localparam logic [6:0] REG_SEL_OUT = 7'h34;
	localparam logic [6:0] REG_MATH_OUT = 7'h38;
	localparam logic [6:0] REG_DW = 7'h40;

	// status / mask bit positions
	localparam int ST_SEL = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int ST_MISSING = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_W = 5;

	// value bounds, hundredths for presets
	localparam logic signed [31:0] PRESET_MAX = 32'sh001e_8480;
	localparam logic signed [31:0] PRESET_MIN = -32'sh001e_8480;
	localparam logic signed [63:0] RESULT_LIMIT = 64'sh0000_0000_05f5_e0ff;

	typedef enum logic [1:0] {OP_ADD = 2'h0, OP_SUB = 2'h1, OP_MUL = 2'h2, OP_DIV = 2'h3} op_t;

	localparam logic [1:0] PRI_HIGH = 2'h0;
	localparam logic [1:0] PRI_MID = 2'h1;
	localparam logic [1:0] PRI_LOW = 2'h2;

	typedef struct packed {
		logic [1:0] pri;
		op_t op;
	} op_cfg_t;

	typedef struct packed {
		logic [1:0] operand_idx;
		logic [1:0] preset_idx;
		logic operand_src_dw;
		logic preset_src_dw;
		logic hold_last;
	} ctrl_t;

	localparam int CTRL_W = 7;

	typedef enum logic [1:0] {MS_IDLE = 2'h1, MS_EVAL = 2'h2} math_state_t;
endpackage

// >>> core/preset_value_selector.sv
// Purpose: four-way preset selector, updated on an enable rising edge
// Assumes: enable and selects come from logic on the same clock
// Notes: value holds between edges
`timescale 1ns/1ps
module preset_value_selector (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// control
	input wire logic enable_i,
	input wire logic select_high_i,
	input wire logic select_low_i,
	input wire logic [3:0][31:0] presets_i,
	// result
	output logic [31:0] value_o,
	output logic update_o
);
	logic enable_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			enable_q <= 1'b0;
		end else begin
			enable_q <= enable_i;
		end
	end

	assign update_o = enable_i & ~enable_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			value_o <= '0;
		end else if (update_o) begin // RL1
			value_o <= presets_i[{select_high_i, select_low_i}]; // RL2
		end
	end
endmodule

// >>> core/math_op_unit.sv
// Purpose: one arithmetic operation with error detection
// Assumes: operands already sign-extended to 64 bits
// Notes: division truncates toward zero
`timescale 1ns/1ps
module math_op_unit (
	// operands
	input wire logic signed [63:0] a_i,
	input wire logic signed [63:0] b_i,
	input wire abm_pkg::op_t op_i,
	// result
	output logic signed [63:0] res_o,
	output logic error_o
);
	logic div_zero;

	always_comb begin
		div_zero = 1'b0;
		unique case (op_i) // RL9
			abm_pkg::OP_ADD: res_o = a_i + b_i;
			abm_pkg::OP_SUB: res_o = a_i - b_i;
			abm_pkg::OP_MUL: res_o = a_i * b_i;
			abm_pkg::OP_DIV: begin
				div_zero = (b_i == '0);
				res_o = div_zero ? a_i : a_i / b_i;
			end
		endcase
	end

	// operands stay at or below 2**31 in magnitude, so one product cannot wrap 64 bits
	assign error_o = div_zero | (res_o > abm_pkg::RESULT_LIMIT)
		| (res_o < -abm_pkg::RESULT_LIMIT); // RL7
endmodule

// >>> tb/program_stub.sv
// Purpose: stands in for the program blocks that drive enables, selects and reset
// Assumes: every change lands by non-blocking assignment on a rising edge
// Notes: the selector enable drops after one cycle so each sel_edge call is a fresh rising edge; math_level holds the math enable
`timescale 1ns/1ps
module program_stub (
	// clock
	input wire logic ref_clk_i,
	// block controls
	output logic sel_enable_o,
	output logic select_high_o,
	output logic select_low_o,
	output logic math_enable_o,
	output logic math_reset_o
);
	initial begin
		sel_enable_o = 1'b0;
		select_high_o = 1'b0;
		select_low_o = 1'b0;
		math_enable_o = 1'b0;
		math_reset_o = 1'b0;
	end
	task automatic set_sel(input logic hi, input logic lo);
		@(posedge ref_clk_i);
		select_high_o <= hi;
		select_low_o <= lo;
	endtask
	task automatic sel_edge(input logic hi, input logic lo);
		set_sel(hi, lo);
		sel_enable_o <= 1'b1;
		@(posedge ref_clk_i);
		sel_enable_o <= 1'b0;
	endtask
	task automatic math_level(input logic v);
		@(posedge ref_clk_i);
		math_enable_o <= v;
	endtask
	task automatic math_rst();
		@(posedge ref_clk_i);
		math_reset_o <= 1'b1;
		@(posedge ref_clk_i);
		math_reset_o <= 1'b0;
	endtask
endmodule

// >>> tb/analog_select_math_test.sv
// Purpose: self-checking bench for the selector and arithmetic blocks
// Assumes: ack one cycle after a request; eval result four edges after the start
// Notes: outputs are judged at the falling edge so the launching edge has landed
`timescale 1ns/1ps
module analog_select_math_test;
	logic ref_clk_i;
	logic rst_i;
	logic cyc;
	logic stb;
	logic we;
	logic [6:0] adr;
	logic [3:0] sel;
	logic [31:0] dat;
	logic [31:0] r;
	wire logic [31:0] dat_o;
	wire logic ack_o;
	wire logic sel_en;
	wire logic s_hi;
	wire logic s_lo;
	wire logic m_en;
	wire logic m_rst;
	wire logic [31:0] sel_value_o;
	wire logic [31:0] sel_param_o;
	wire logic [31:0] arith_result_o;
	wire logic [31:0] math_param_o;
	wire logic math_error_o;
	wire logic irq_o;
	int n_fail;
	int checks_done;
	analog_select_math i_analog_select_math (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .sel_enable_i(sel_en), .select_high_i(s_hi),
		.select_low_i(s_lo), .sel_value_o(sel_value_o), .sel_param_o(sel_param_o),
		.math_enable_i(m_en), .math_reset_i(m_rst), .arith_result_o(arith_result_o),
		.math_param_o(math_param_o), .math_error_o(math_error_o), .irq_o(irq_o));
	program_stub i_program_stub (.ref_clk_i(ref_clk_i), .sel_enable_o(sel_en),
		.select_high_o(s_hi), .select_low_o(s_lo), .math_enable_o(m_en),
		.math_reset_o(m_rst));
	always #25 ref_clk_i = ~ref_clk_i;
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// request held until ack is sampled high; then a cycle of idle follows
	task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		dat <= d;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("MISMATCH at %0t: no ack", $time);
			conclude();
		end
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(r, exp);
	endtask
	task automatic t_reset();
		@(negedge ref_clk_i);
		check(arith_result_o, 32'h0);
		check(sel_value_o, 32'h0);
		rdchk(7'h00, 32'h0);
		rdchk(7'h30, 32'h00000840);
		rdchk(7'h0c, 32'h2);
		rdchk(7'h7c, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_select();
		logic [31:0] p [4];
		p = '{32'h001e8480, 32'h00000064, 32'hfffffc18, 32'hffe17b80};
		for (int i = 0; i < 4; i++) begin
			wr(7'h10 + 7'(4 * i), p[i]);
		end
		for (int i = 0; i < 4; i++) begin
			i_program_stub.sel_edge(i[1], i[0]);
			@(negedge ref_clk_i);
			check(sel_value_o, p[i]);
			@(negedge ref_clk_i);
			check(sel_param_o, p[i]);
		end
		i_program_stub.set_sel(1'b0, 1'b0);
		repeat (3) @(negedge ref_clk_i);
		check(sel_value_o, p[3]);
		rdchk(7'h34, p[3]);
		wr(7'h04, 32'h1f);
		wr(7'h14, 32'h001e8481);
		rdchk(7'h14, 32'h00000064);
		rdchk(7'h04, 32'h10);
		$display("test select done");
	endtask
	task automatic t_shared();
		wr(7'h04, 32'h1f);
		wr(7'h48, 32'h00003039);
		wr(7'h00, 32'h13);
		i_program_stub.sel_edge(1'b0, 1'b0);
		@(negedge ref_clk_i);
		check(sel_value_o, 32'h00003039);
		rdchk(7'h40, 32'h00003039);
		wr(7'h10, 32'h5);
		rdchk(7'h10, 32'h001e8480);
		rdchk(7'h04, 32'h11);
		wr(7'h04, 32'h1f);
		wr(7'h00, 32'h1b);
		i_program_stub.sel_edge(1'b0, 1'b0);
		rdchk(7'h04, 32'h09);
		check(sel_value_o, 32'h0);
		wr(7'h00, 32'h01);
		$display("test shared done");
	endtask
	task automatic t_irq();
		wr(7'h04, 32'h1f);
		wr(7'h08, 32'h01);
		@(negedge ref_clk_i);
		check({31'h0, irq_o}, 32'h0);
		i_program_stub.sel_edge(1'b0, 1'b1);
		@(negedge ref_clk_i);
		check({31'h0, irq_o}, 32'h1);
		wr(7'h08, 32'h0);
		@(negedge ref_clk_i);
		check({31'h0, irq_o}, 32'h0);
		wr(7'h08, 32'h01);
		@(negedge ref_clk_i);
		check({31'h0, irq_o}, 32'h1);
		wr(7'h04, 32'h01);
		@(negedge ref_clk_i);
		check({31'h0, irq_o}, 32'h0);
		$display("test irq done");
	endtask
	task automatic run_math(input logic [31:0] cfg, a, b, c, d, exp, input logic err);
		wr(7'h30, cfg);
		wr(7'h20, a);
		wr(7'h24, b);
		wr(7'h28, c);
		wr(7'h2c, d);
		i_program_stub.math_level(1'b1);
		repeat (6) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check(arith_result_o, exp);
		check({31'h0, math_error_o}, {31'h0, err});
		check(math_param_o, exp);
		rdchk(7'h38, exp);
		i_program_stub.math_level(1'b0);
	endtask
	task automatic t_math();
		wr(7'h00, 32'h01);
		run_math(32'h528, 32'h2, 32'h3, 32'h4, 32'h5, 32'h9, 1'b0);
		run_math(32'h683, 32'hffffff9c, 32'h7, 32'h0, 32'h1, 32'hfffffff2, 1'b0);
		run_math(32'h683, 32'h5, 32'h0, 32'h0, 32'h1, 32'hfffffff2, 1'b1);
		i_program_stub.math_rst();
		@(negedge ref_clk_i);
		check(arith_result_o, 32'h0);
		check({31'h0, math_error_o}, 32'h0);
		run_math(32'h682, 32'h2710, 32'h2710, 32'h0, 32'h1, 32'h0, 1'b1);
		i_program_stub.math_rst();
		run_math(32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 1'b1);
		i_program_stub.math_rst();
		wr(7'h00, 32'h45);
		run_math(32'h528, 32'h0, 32'h3, 32'h4, 32'h5, 32'h3040, 1'b0);
		wr(7'h00, 32'h0);
		run_math(32'h528, 32'h2, 32'h3, 32'h4, 32'h5, 32'h9, 1'b0);
		repeat (2) @(negedge ref_clk_i);
		check(arith_result_o, 32'h0);
		$display("test math done");
	endtask
	initial begin
		ref_clk_i = 1'b0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 7'h0;
		sel = 4'hf;
		dat = 32'h0;
		n_fail = 0;
		checks_done = 0;
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_select();
		t_shared();
		t_irq();
		t_math();
		conclude();
	end
endmodule
